//--- hw/dbs_params.svh
`ifndef DBS_PARAMS_SVH
`define DBS_PARAMS_SVH

// ----------------------------------------------------------------------
// Operand request word layout
// ----------------------------------------------------------------------
`define OP_WIDTH        69
`define OP_DATA_LSB     0
`define OP_ADDR_LSB     32
`define OP_LEN_LSB      64
`define OP_WRITE_BIT    66
`define OP_IO_BIT       67
`define OP_COPROC_BIT   68

// ----------------------------------------------------------------------
// Operand lengths
// ----------------------------------------------------------------------
`define LEN_BYTE        2'h0
`define LEN_WORD        2'h1
`define MASK_BYTE       8'h01
`define MASK_WORD       8'h03
`define MASK_DWORD      8'h0F

// ----------------------------------------------------------------------
// Lane groups and address spaces
// ----------------------------------------------------------------------
`define LOW_HALF        4'h3
`define HIGH_HALF       4'hC
`define IO_ADDR_MASK    32'h0000FFFF
`define COPROC_BASE     32'h800000F8
`define COPROC_OFS_MASK 32'h00000007

// ----------------------------------------------------------------------
// Buffering and limits
// ----------------------------------------------------------------------
`define FIFO_DEPTH      4
`define MAX_CYCLES      3'h3

`endif

//--- hw/dbs_pkg.sv
package dbs_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_ISSUE = 2'b01,
    BUS_ADDR  = 2'b10,
    BUS_DATA  = 2'b11
  } bus_state_e;

endpackage : dbs_pkg

//--- hw/op_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module op_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign inReady  = (count_q != DEPTH[AW:0]);
  assign outValid = (count_q != '0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr_q];

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  // ----------------------------------------------------------------------
  // Pointers and fill level
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
      end
      count_q <= count_q + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
    end
  end

endmodule : op_fifo

`default_nettype wire

//--- hw/dynamic_bus_sizing_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbs_params.svh"

module dynamic_bus_sizing_unit
  import dbs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        reqValid,
  output logic             reqReady,
  input  wire logic        reqWrite,
  input  wire logic        reqIo,
  input  wire logic        reqCoproc,
  input  wire logic [1:0]  reqLen,
  input  wire logic [31:0] reqAddr,
  input  wire logic [31:0] reqData,
  output logic             rspValid,
  output logic      [31:0] rspData,
  output logic             busStart_n,
  output logic      [29:0] dwordAddress,
  output logic      [3:0]  laneSelect_n,
  output logic             memIo,
  output logic             writeRead,
  input  wire logic        readyIn_n,
  input  wire logic        narrowPort_n,
  input  wire logic [31:0] dataLinesIn,
  output logic      [31:0] dataLinesOut,
  output logic             dataLinesOe
);

  // ----------------------------------------------------------------------
  // Request buffer
  // ----------------------------------------------------------------------
  logic [`OP_WIDTH-1:0] fifoIn;
  logic [`OP_WIDTH-1:0] fifoOut;
  logic                 fifoValid;
  logic                 fifoReady;

  assign fifoIn = {reqCoproc, reqIo, reqWrite, reqLen, reqAddr, reqData};

  op_fifo #(
    .WIDTH (`OP_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .resetn   (resetn),
    .inValid  (reqValid),
    .inReady  (reqReady),
    .inData   (fifoIn),
    .outValid (fifoValid),
    .outReady (fifoReady),
    .outData  (fifoOut)
  );

  // ----------------------------------------------------------------------
  // Operand decode
  // ----------------------------------------------------------------------
  bus_state_e  state_q;
  logic        respPend_q;
  logic [31:0] inAddr;
  logic [31:0] effAddr;
  logic [1:0]  inLen;
  logic [7:0]  lenMask;
  logic        pop;

  assign inAddr = fifoOut[`OP_ADDR_LSB +: 32];
  assign inLen  = fifoOut[`OP_LEN_LSB +: 2];
  assign pop    = fifoValid && fifoReady;
  assign fifoReady = (state_q == BUS_IDLE) && !respPend_q;

  always_comb begin
    if (fifoOut[`OP_COPROC_BIT]) begin
      effAddr = `COPROC_BASE | (inAddr & `COPROC_OFS_MASK);
    end else if (fifoOut[`OP_IO_BIT]) begin
      effAddr = inAddr & `IO_ADDR_MASK;
    end else begin
      effAddr = inAddr;
    end
    case (inLen)
      `LEN_BYTE: lenMask = `MASK_BYTE;
      `LEN_WORD: lenMask = `MASK_WORD;
      default:   lenMask = `MASK_DWORD;
    endcase
  end

  // ----------------------------------------------------------------------
  // Operand registers
  // ----------------------------------------------------------------------
  logic [31:0] opAddr_q;
  logic        opWrite_q;
  logic        opIo_q;
  logic [7:0]  opMask_q;
  logic [1:0]  opOff_q;
  logic [63:0] opData_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      opAddr_q  <= '0;
      opWrite_q <= 1'b0;
      opIo_q    <= 1'b0;
      opMask_q  <= '0;
      opOff_q   <= '0;
      opData_q  <= '0;
    end else if (pop) begin
      opAddr_q  <= effAddr;
      opWrite_q <= fifoOut[`OP_WRITE_BIT];
      opIo_q    <= fifoOut[`OP_IO_BIT] || fifoOut[`OP_COPROC_BIT];
      opMask_q  <= lenMask << effAddr[1:0];
      opOff_q   <= effAddr[1:0];
      opData_q  <= {32'h0, fifoOut[`OP_DATA_LSB +: 32]} << {effAddr[1:0], 3'h0};
    end
  end

  // ----------------------------------------------------------------------
  // Current cycle lanes and data
  // ----------------------------------------------------------------------
  logic        dwSel_q;
  logic        half_q;
  logic [3:0]  curLanes;
  logic [3:0]  cycLanes;
  logic [31:0] curWord;
  logic [31:0] wrData;
  logic [3:0]  act;
  logic        busDone;
  logic        needSplit;
  logic        moreLow;

  assign curLanes = dwSel_q ? opMask_q[7:4] : opMask_q[3:0];
  assign cycLanes = half_q ? (curLanes & `HIGH_HALF) : curLanes;
  assign curWord  = dwSel_q ? opData_q[63:32] : opData_q[31:0];
  // Upper half only: copy the upper bytes onto the low lines
  assign wrData   = ((cycLanes & `LOW_HALF) == 4'h0) ?
                    {curWord[31:16], curWord[31:16]} : curWord;
  assign act      = ~laneSelect_n;
  assign busDone  = (state_q == BUS_DATA) && !readyIn_n;
  assign needSplit = !narrowPort_n && act[1] && act[2] && !half_q;
  assign moreLow  = dwSel_q && (opMask_q[3:0] != 4'h0);

  // ----------------------------------------------------------------------
  // Bus sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= BUS_IDLE;
      dwSel_q <= 1'b0;
      half_q  <= 1'b0;
    end else begin
      case (state_q)
        BUS_IDLE: begin
          if (pop) begin
            state_q <= BUS_ISSUE;
            half_q  <= 1'b0;
            // Highest-order dword goes first
            dwSel_q <= (lenMask << effAddr[1:0]) > 8'h0F;
          end
        end
        BUS_ISSUE: begin
          state_q <= BUS_ADDR;
        end
        BUS_ADDR: begin
          state_q <= BUS_DATA;
        end
        BUS_DATA: begin
          if (busDone) begin
            if (needSplit) begin
              half_q  <= 1'b1;
              state_q <= BUS_ISSUE;
            end else if (moreLow) begin
              half_q  <= 1'b0;
              dwSel_q <= 1'b0;
              state_q <= BUS_ISSUE;
            end else begin
              half_q  <= 1'b0;
              state_q <= BUS_IDLE;
            end
          end
        end
        default: begin
          state_q <= BUS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Bus outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busStart_n   <= 1'b1;
      dwordAddress <= '0;
      laneSelect_n <= 4'hF;
      memIo        <= 1'b1;
      writeRead    <= 1'b0;
      dataLinesOut <= '0;
      dataLinesOe  <= 1'b0;
    end else begin
      case (state_q)
        BUS_ISSUE: begin
          busStart_n   <= 1'b0;
          dwordAddress <= opAddr_q[31:2] + {29'h0, dwSel_q};
          laneSelect_n <= ~cycLanes;
          memIo        <= !opIo_q;
          writeRead    <= opWrite_q;
          dataLinesOut <= wrData;
          dataLinesOe  <= opWrite_q;
        end
        BUS_ADDR: begin
          busStart_n <= 1'b1;
        end
        BUS_DATA: begin
          if (busDone) begin
            laneSelect_n <= 4'hF;
            dataLinesOe  <= 1'b0;
          end
        end
        default: begin
          busStart_n <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read capture, one byte per operand window position
  // ----------------------------------------------------------------------
  logic [63:0] rdData_q;

  for (genvar j = 0; j < 8; j++) begin : g_cap
    localparam int LANE = j % 4;
    logic [7:0] src;
    logic       take;
    // Narrow ports return lanes 2 and 3 on the low lines
    assign src  = (!narrowPort_n && LANE >= 2) ? dataLinesIn[(LANE % 2)*8 +: 8]
                                               : dataLinesIn[LANE*8 +: 8];
    assign take = busDone && !opWrite_q && act[LANE] && (dwSel_q == (j >= 4))
                  && !(needSplit && LANE >= 2);
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        rdData_q[j*8 +: 8] <= 8'h0;
      end else if (pop) begin
        rdData_q[j*8 +: 8] <= 8'h0;
      end else if (take) begin
        rdData_q[j*8 +: 8] <= src;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Operand completion
  // ----------------------------------------------------------------------
  logic [63:0] rdShift;

  assign rdShift = rdData_q >> {opOff_q, 3'h0};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      respPend_q <= 1'b0;
      rspValid   <= 1'b0;
      rspData    <= '0;
    end else begin
      rspValid <= 1'b0;
      if (busDone && !needSplit && !moreLow) begin
        respPend_q <= 1'b1;
      end else if (respPend_q) begin
        respPend_q <= 1'b0;
        rspValid   <= 1'b1;
        rspData    <= opWrite_q ? 32'h0 : (rdShift[31:0] & {
                      {8{opMask_q[{1'b0, opOff_q} + 3'h3]}},
                      {8{opMask_q[{1'b0, opOff_q} + 3'h2]}},
                      {8{opMask_q[{1'b0, opOff_q} + 3'h1]}},
                      8'hFF});
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [2:0] cycCnt_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cycCnt_q <= '0;
    end else if (pop) begin
      cycCnt_q <= '0;
    end else if (state_q == BUS_ISSUE) begin
      cycCnt_q <= cycCnt_q + 3'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_lanes;
    state_q == BUS_DATA |-> (act == cycLanes) && (act != 4'h0);
  endproperty
  a_lanes: assert property (p_lanes) else $error("lane selects differ from lanes used");

  property p_contig;
    !busStart_n |-> act inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hC, 4'h7, 4'hE, 4'hF};
  endproperty
  a_contig: assert property (p_contig) else $error("lane selects not contiguous");

  property p_two_states;
    $fell(busStart_n) |=> busStart_n [*2];
  endproperty
  a_two_states: assert property (p_two_states) else $error("bus cycle shorter than two states");

  property p_cycle_count;
    rspValid |-> (cycCnt_q >= 3'h1) && (cycCnt_q <= `MAX_CYCLES);
  endproperty
  a_cycle_count: assert property (p_cycle_count) else $error("operand took too many cycles");

  property p_io_range;
    !busStart_n && !memIo && !dwordAddress[29] |-> dwordAddress[29:14] == 16'h0;
  endproperty
  a_io_range: assert property (p_io_range) else $error("I/O address above low range");

  property p_coproc;
    !busStart_n && !memIo && dwordAddress[29] |-> dwordAddress[29:1] == 29'(`COPROC_BASE >> 3);
  endproperty
  a_coproc: assert property (p_coproc) else $error("coprocessor address outside block");

  property p_dup_upper;
    dataLinesOe && laneSelect_n[1:0] == 2'h3 |-> dataLinesOut[15:0] == dataLinesOut[31:16];
  endproperty
  a_dup_upper: assert property (p_dup_upper) else $error("upper bytes not copied down");

  property p_split_next;
    busDone && !narrowPort_n && act[1] && act[2] && !half_q
      |-> ##2 (!busStart_n && half_q && dwordAddress == $past(dwordAddress, 2));
  endproperty
  a_split_next: assert property (p_split_next) else $error("split second cycle missing");

  property p_second_half;
    state_q == BUS_ADDR && half_q |-> laneSelect_n[1:0] == 2'h3 && act[3:2] != 2'h0;
  endproperty
  a_second_half: assert property (p_second_half) else $error("low lanes active in second half");

  property p_low_only;
    busDone && laneSelect_n[3:2] == 2'h3 |=> !half_q;
  endproperty
  a_low_only: assert property (p_low_only) else $error("narrow port split a low-half cycle");

  property p_wide_nosplit;
    busDone && narrowPort_n |=> !half_q;
  endproperty
  a_wide_nosplit: assert property (p_wide_nosplit) else $error("wide port cycle was split");

  c_split_read:  cover property (busDone && needSplit && !opWrite_q);
  c_split_write: cover property (busDone && needSplit && opWrite_q);
  c_three:       cover property (rspValid && cycCnt_q == `MAX_CYCLES);
  c_fifo_full:   cover property (reqValid && !reqReady);

endmodule : dynamic_bus_sizing_unit

`default_nettype wire

//--- testbench/bus_partner_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Memory and I/O slave; every odd dword address answers as a 16-bit port
// ----------------------------------------------------------------------
module bus_partner_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        busStart_n,
  input  wire logic [29:0] dwordAddress,
  input  wire logic [3:0]  laneSelect_n,
  input  wire logic        memIo,
  input  wire logic        writeRead,
  input  wire logic [31:0] dataLinesOut,
  input  wire logic        dataLinesOe,
  input  wire logic [1:0]  waitCfg,
  output logic             readyIn_n,
  output logic             narrowPort_n,
  output logic      [31:0] dataLinesIn,
  output int               protoErrors
);
  logic [7:0] mem [logic [32:0]];

  function automatic logic [7:0] peek(input logic [32:0] k);
    return mem.exists(k) ? mem[k] : (k[7:0] ^ k[15:8] ^ 8'h3C);
  endfunction : peek

  initial begin : serve
    logic [31:0] base;
    logic [31:0] w;
    logic [31:0] rd;
    logic [3:0]  en;
    logic [1:0]  lo;
    logic [1:0]  nWait;
    logic        start;
    logic        nar;
    logic        low;
    int          i;
    readyIn_n    = 1'b1;
    narrowPort_n = 1'b1;
    dataLinesIn  = 32'h0;
    protoErrors  = 0;
    forever begin
      @(posedge clk);
      start = (resetn === 1'b1) && (busStart_n === 1'b0);
      nWait = waitCfg;
      #1;
      if (!start)
        dataLinesIn = ~dataLinesIn;
      if (start) begin
        en   = ~laneSelect_n;
        lo   = en[0] ? 2'h0 : en[1] ? 2'h1 : en[2] ? 2'h2 : 2'h3;
        base = {dwordAddress, lo};
        nar  = dwordAddress[0];
        low  = en[0] | en[1];
        if (!(en inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hC, 4'h7, 4'hE, 4'hF}))
          protoErrors++;
        repeat (nWait) begin
          dataLinesIn = ~dataLinesIn;
          @(posedge clk);
          #1;
        end
        for (i = 0; i < 4; i++)
          w[8*i+:8] = en[i] ? peek({memIo, base + i - lo}) : 8'hA5;
        if (nar)
          rd = low ? {~w[31:16], w[15:0]} : {~w[31:16], w[31:16]};
        else
          rd = w;
        dataLinesIn  = rd;
        readyIn_n    = 1'b0;
        narrowPort_n = !nar;
        if (writeRead) begin
          if (dataLinesOe !== 1'b1)
            protoErrors++;
          for (i = 0; i < 4; i++)
            if (en[i] && (!nar || (low == (i < 2))))
              mem[{memIo, base + i - lo}] = nar ? dataLinesOut[8*(i%2)+:8] : dataLinesOut[8*i+:8];
        end
        @(posedge clk);
        #1 readyIn_n = 1'b1;
        narrowPort_n = nar;
        dataLinesIn  = ~rd;
      end
    end
  end
endmodule : bus_partner_model

`default_nettype wire

//--- testbench/dynamic_bus_sizing_unit_test.sv
`timescale 1ns/1ps
`default_nettype none

module dynamic_bus_sizing_unit_test
  import dbs_pkg::*;
;
  logic        clk, resetn, reqValid, reqReady, reqWrite, reqIo, reqCoproc;
  logic [1:0]  reqLen, waitCfg;
  logic [31:0] reqAddr, reqData, rspData, dataLinesIn, dataLinesOut;
  logic        rspValid, busStart_n, memIo, writeRead, readyIn_n, narrowPort_n, dataLinesOe;
  logic [29:0] dwordAddress;
  logic [3:0]  laneSelect_n;
  int          protoErrors, n_errors, check_count, n, k;
  logic        sawFull, slow, wr;
  logic [1:0]  rl, sp;
  logic [31:0] a;
  logic [7:0]  mirror [logic [32:0]];
  logic [36:0] cycQ [$];
  logic [31:0] rspQ [$];

  dynamic_bus_sizing_unit u_dynamic_bus_sizing_unit (.clk(clk), .resetn(resetn),
    .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite), .reqIo(reqIo),
    .reqCoproc(reqCoproc), .reqLen(reqLen), .reqAddr(reqAddr), .reqData(reqData),
    .rspValid(rspValid), .rspData(rspData), .busStart_n(busStart_n),
    .dwordAddress(dwordAddress), .laneSelect_n(laneSelect_n), .memIo(memIo),
    .writeRead(writeRead), .readyIn_n(readyIn_n), .narrowPort_n(narrowPort_n),
    .dataLinesIn(dataLinesIn), .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe));

  bus_partner_model u_bus_partner_model (.clk(clk), .resetn(resetn), .busStart_n(busStart_n),
    .dwordAddress(dwordAddress), .laneSelect_n(laneSelect_n), .memIo(memIo),
    .writeRead(writeRead), .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe),
    .waitCfg(waitCfg), .readyIn_n(readyIn_n), .narrowPort_n(narrowPort_n),
    .dataLinesIn(dataLinesIn), .protoErrors(protoErrors));

  always #20 clk = ~clk;

  // ----------------------------------------------------------------------
  // Compare and verdict
  // ----------------------------------------------------------------------
  task automatic check_cycle(input logic [36:0] exp, input logic [36:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t cycle exp %h got %h", $time, exp, got);
    end
  endtask : check_cycle

  task automatic check_data(input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t data exp %h got %h", $time, exp, got);
    end
  endtask : check_data

  task automatic give_verdict;
    n_errors = n_errors + protoErrors;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------------
  // Reference model and request driver
  // ----------------------------------------------------------------------
  task automatic push(input logic w, io, cp, input logic [1:0] l, input logic [31:0] ad, d);
    logic [31:0] eff, rsp, hi, lo;
    logic [29:0] dw;
    logic [3:0]  m;
    logic        ms;
    int          i, j, t, cnt;
    cnt = (l == 2'h0) ? 1 : (l == 2'h1) ? 2 : 4;
    ms  = !(io || cp);
    eff = cp ? (32'h800000F8 | (ad & 32'h7)) : io ? (ad & 32'hFFFF) : ad;
    rsp = 32'h0;
    for (i = 0; i < cnt; i++)
      if (w) mirror[{ms, eff + i}] = d[8*i+:8];
      else rsp[8*i+:8] = mirror.exists({ms, eff + i}) ? mirror[{ms, eff + i}]
                       : ((eff[7:0] + i[7:0]) ^ (eff + i) >> 8 ^ 8'h3C);
    rspQ.push_back(w ? 32'h0 : rsp);
    hi = (eff + cnt - 1) >> 2;
    lo = eff >> 2;
    for (j = 0; j < 2 && !(j == 1 && hi == lo); j++) begin
      dw = (j == 0) ? hi[29:0] : lo[29:0];
      m  = 4'h0;
      for (i = 0; i < cnt; i++)
        if (((eff + i) >> 2) == {2'h0, dw}) m[(eff + i) & 3] = 1'b1;
      if (dw[0] && m[1] && m[2]) begin
        cycQ.push_back({w, w, ms, dw, ~m});
        cycQ.push_back({w, w, ms, dw, ~(m & 4'hC)});
      end else
        cycQ.push_back({w, w, ms, dw, ~m});
    end
    #1;
    reqValid = 1'b1; reqWrite = w; reqIo = io; reqCoproc = cp;
    reqLen = l; reqAddr = ad; reqData = d;
    waitCfg = slow ? 2'h3 : 2'($urandom % 3);
    t = 0;
    do begin
      @(posedge clk);
      if (reqReady !== 1'b1) sawFull = 1'b1;
      t++;
    end while (reqReady !== 1'b1 && t < 200);
  endtask : push

  task automatic drain;
    int t;
    #1 reqValid = 1'b0;
    t = 0;
    while ((rspQ.size() != 0 || cycQ.size() != 0) && t < 3000) begin
      @(posedge clk);
      t++;
    end
    check_data(32'h0, rspQ.size() + cycQ.size());
  endtask : drain

  // ----------------------------------------------------------------------
  // Bus and response monitor
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (resetn === 1'b1 && busStart_n === 1'b0) begin
      check_cycle(cycQ.size() ? cycQ.pop_front() : '1,
                  {writeRead, dataLinesOe, memIo, dwordAddress, laneSelect_n});
      if (writeRead === 1'b1 && laneSelect_n[1:0] === 2'b11)
        check_data({16'h0, dataLinesOut[31:16]}, {16'h0, dataLinesOut[15:0]});
    end
    if (resetn === 1'b1 && rspValid === 1'b1)
      check_data(rspQ.size() ? rspQ.pop_front() : '1, rspData);
  end

  initial begin
    #800000;
    n_errors++;
    $display("[ERR] %0t watchdog exp %h got %h", $time, 1, 0);
    give_verdict();
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0; resetn = 1'b0; reqValid = 1'b0; reqWrite = 1'b0; reqIo = 1'b0;
    reqCoproc = 1'b0; reqLen = 2'h0; reqAddr = 32'h0; reqData = 32'h0; waitCfg = 2'h0;
    n_errors = 0; check_count = 0; sawFull = 1'b0; slow = 1'b0;
    void'($urandom(1193));
    repeat (2) @(posedge clk);
    #1 resetn = 1'b1;
    @(posedge clk);
    for (k = 0; k < 48; k++)
      push(1'(k / 24), 1'b0, 1'b0, 2'((k / 4) % 3), 32'h100 + 4 * ((k / 12) % 2) + k % 4, $urandom);
    drain();
    for (k = 0; k < 12; k++)
      push(1'(k % 2), k < 6, k >= 6, 2'((k / 2) % 3), k < 6 ? 32'hABCD1235 : 32'h4, $urandom);
    drain();
    repeat (60) begin
      rl = 2'($urandom % 4);
      sp = 2'($urandom % 3);
      n  = (rl == 2'h0) ? 1 : (rl == 2'h1) ? 2 : 4;
      wr = 1'($urandom % 2);
      a  = (sp == 2'h2) ? $urandom % (9 - n) : 32'h200 + $urandom % 64;
      push(wr, sp == 2'h1, sp == 2'h2, rl, a, $urandom);
    end
    drain();
    slow = 1'b1;
    sawFull = 1'b0;
    repeat (8) push(1'b0, 1'b0, 1'b0, 2'h2, 32'h300, 32'h0);
    check_data(32'h1, {31'h0, sawFull});
    drain();
    check_data(32'h1, {31'h0, reqReady});
    give_verdict();
  end
endmodule : dynamic_bus_sizing_unit_test

`default_nettype wire
